// File: hw/can_lowpower_mode_control.sv
// Mode and low-power control for a CAN controller core.
// Assumes the protocol engine gives bit-rate enables and frame events
// on mclk; CPU run/wait/stop levels are synchronous to mclk.
`default_nettype none
// ============================================================
// Module
// Summary of operation
// R1: Timer captured at end of valid frame
// R2: Listen-only receives, drives only recessive
// R3: Listen-only never starts transmission
// R4: Listen-only dominant bits loop back internally
// R5: Module disable stops all clocks
// R6: Sleep keeps only register clock
// R7: Power-down stops every clock
// R8: Wake irq needs sleep, enable, irq enable
// R9: Stop or wait-with-stop forces power-down
// R10: Leaving wait power-down restarts, normal mode
// R11: Wait without stop keeps normal/sleep
// R12: Sleep after sync delay plus activity
// R13: Pending transmit buffers finish before sleep
// R14: Reception finishes, sleep at bus idle
// R15: Idle controller sleeps immediately
// R16: Host avoids scheduling then sleeping
// R17: Acknowledge marks sleep active
// R18: Bus-off recovery frozen while asleep
// R19: Sleep allows reads, blocks foreground shift
// R20: Sleep allows buffer access, no aborts
// R21: No wake enable holds receive recessive
// R22: Wake on activity or request clear
// R23: Wait eleven recessive bits after wake
// R24: Request clear ignored until sleep active
// R25: Power-down or init forces transmit recessive
// R26: CPU state levels are synchronous
module can_lowpower_mode_control (
   input wire logic mclk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // CPU mode levels
   input wire logic cpuWait,
   input wire logic cpuStop,
   // Protocol engine side
   input wire logic bitTick,
   input wire logic [15:0] timerValue,
   input wire logic frameEnd,
   input wire logic txActive,
   input wire logic rxActive,
   input wire logic busIdle,
   input wire logic busOff,
   input wire logic [2:0] txBufferEmptyFlag,
   input wire logic macTx,
   input wire logic abortReq,
   input wire logic shiftReq,
   input wire logic busReceivePinRaw,
   // Outputs
   output logic busTransmitPin,
   output logic macRx,
   output logic coreClkEn,
   output logic regClkEn,
   output logic txStartAllow,
   output logic abortAllow,
   output logic shiftAllow,
   output logic recovCountEn,
   output logic stampWrite,
   output logic [15:0] stampValue,
   output logic wakeIrq
);
   // Control register bits
   logic [7:0] ctrl_q;
   logic sleepAck_q;
   can_lpm_pkg::mode_e mode_q;
   logic [1:0] syncCnt_q;
   logic [3:0] idleCnt_q;
   logic [2:0] rxSync_q;
   logic rxClean_q;
   logic wakeFlag_q;
   logic pdn_q;
   logic [15:0] lastStamp_q;
   logic rdLoad; // Read seen in its first cycle
   logic wrTake; // Write taken at this edge

   // Decoded control bits
   logic sleepReq, wakeEn, wakeIrqEn, stopInWait, listenOnly;
   logic timeEn, moduleEnable, initMode, powerDown, asleep;
   logic rxFiltered, busActivity, anyPending;
   assign sleepReq = ctrl_q[can_lpm_pkg::CTRL_SLEEP];
   assign wakeEn = ctrl_q[can_lpm_pkg::CTRL_WAKE];
   assign wakeIrqEn = ctrl_q[can_lpm_pkg::CTRL_WAKEIRQ];
   assign stopInWait = ctrl_q[can_lpm_pkg::CTRL_STOPWAI];
   assign listenOnly = ctrl_q[can_lpm_pkg::CTRL_LISTEN];
   assign timeEn = ctrl_q[can_lpm_pkg::CTRL_TIMEEN];
   assign moduleEnable = ctrl_q[can_lpm_pkg::CTRL_ENABLE];
   assign initMode = ctrl_q[can_lpm_pkg::CTRL_INIT];
   // Stop, or wait with stop-in-wait; sleep state ignored
   assign powerDown = cpuStop | (cpuWait & stopInWait); // [R9] [R26]
   assign asleep = (mode_q == can_lpm_pkg::MODE_SLEEP);
   assign anyPending = ~(&txBufferEmptyFlag);
   // Receive masked recessive while asleep without wake enable
   assign rxFiltered = (asleep & ~wakeEn) ? 1'b1 : rxClean_q; // [R21]
   assign busActivity = asleep & wakeEn & ~rxClean_q;
   // Bus requests: reads load data, writes land in the answer cycle
   assign rdLoad = avsRead & avsWaitRequest;
   assign wrTake = avsWrite & ~avsWaitRequest;

   // ============================================================
   // Receive pin synchroniser, change taken when stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rxSync_q <= 3'h7;
         rxClean_q <= 1'b1;
      end else begin
         rxSync_q <= {rxSync_q[1:0], busReceivePinRaw};
         if (rxSync_q[1] == rxSync_q[2]) begin
            rxClean_q <= rxSync_q[2];
         end
      end
   end

   // ============================================================
   // Register writes; request clear ignored until sleep active
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_q <= 8'h00;
      end else begin
         if (wrTake && avsAddress == can_lpm_pkg::ADDR_CTRL &&
             avsByteEnable[0]) begin
            ctrl_q[7:1] <= avsWriteData[7:1];
            // A clear only counts once sleep is active
            if (avsWriteData[can_lpm_pkg::CTRL_SLEEP] ||
                (sleepReq && sleepAck_q)) begin
               ctrl_q[can_lpm_pkg::CTRL_SLEEP] <=
                  avsWriteData[can_lpm_pkg::CTRL_SLEEP]; // [R24]
            end
         end
         // Bus activity with wake enable drops the request
         if (busActivity) begin
            ctrl_q[can_lpm_pkg::CTRL_SLEEP] <= 1'b0; // [R22]
         end
      end
   end

   // ============================================================
   // Sleep handshake state machine
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_q <= can_lpm_pkg::MODE_NORMAL;
         syncCnt_q <= 2'h0;
         idleCnt_q <= 4'h0;
         sleepAck_q <= 1'b0;
      end else if (powerDown || !moduleEnable) begin
         // Activity halted; outside sleep, restart via recovery on exit
         if (mode_q != can_lpm_pkg::MODE_SLEEP) begin
            mode_q <= can_lpm_pkg::MODE_RECOVER; // [R10]
            idleCnt_q <= 4'h0;
         end
      end else begin
         case (mode_q)
            can_lpm_pkg::MODE_NORMAL: begin
               // Runs normally, also in wait without stop
               if (sleepReq) begin // [R11]
                  mode_q <= can_lpm_pkg::MODE_PENDING;
                  syncCnt_q <= 2'h0;
               end
            end
            can_lpm_pkg::MODE_PENDING: begin
               if (!sleepReq) begin
                  mode_q <= can_lpm_pkg::MODE_NORMAL;
               end else if (syncCnt_q != can_lpm_pkg::SYNC_DELAY) begin
                  syncCnt_q <= syncCnt_q + 2'h1; // [R12]
               end else if (!anyPending && !txActive && // [R13]
                            !rxActive && busIdle) begin // [R14] [R15]
                  mode_q <= can_lpm_pkg::MODE_SLEEP;
                  sleepAck_q <= 1'b1; // [R17]
               end
            end
            can_lpm_pkg::MODE_SLEEP: begin
               if (!sleepReq) begin
                  mode_q <= can_lpm_pkg::MODE_RECOVER; // [R22]
                  sleepAck_q <= 1'b0;
                  idleCnt_q <= 4'h0;
               end
            end
            can_lpm_pkg::MODE_RECOVER: begin
               // Count recessive bits before rejoining the bus
               if (bitTick) begin
                  if (!rxClean_q) begin
                     idleCnt_q <= 4'h0;
                  end else if (idleCnt_q ==
                               can_lpm_pkg::WAKE_IDLE_BITS - 4'h1) begin
                     mode_q <= can_lpm_pkg::MODE_NORMAL; // [R23]
                  end else begin
                     idleCnt_q <= idleCnt_q + 4'h1;
                  end
               end
            end
            default: mode_q <= can_lpm_pkg::MODE_NORMAL;
         endcase
      end
   end

   // ============================================================
   // Clock gates, bus pin and permissions
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         coreClkEn <= 1'b0;
         regClkEn <= 1'b0;
         busTransmitPin <= 1'b1;
         macRx <= 1'b1;
         txStartAllow <= 1'b0;
         abortAllow <= 1'b0;
         shiftAllow <= 1'b0;
         recovCountEn <= 1'b0;
      end else begin
         coreClkEn <= moduleEnable & ~powerDown & ~asleep; // [R5] [R6] [R7]
         regClkEn <= moduleEnable & ~powerDown; // [R6] [R7]
         // Listen-only or forced modes keep the pin recessive
         busTransmitPin <= (listenOnly | powerDown | initMode |
                            asleep | ~moduleEnable) ? 1'b1 : macTx; // [R2] [R18] [R25]
         // In listen-only, dominant bits loop back into the monitor path
         macRx <= rxFiltered & (listenOnly ? macTx : 1'b1); // [R4]
         txStartAllow <= ~listenOnly & (mode_q == can_lpm_pkg::MODE_NORMAL)
                         & moduleEnable & ~powerDown & ~initMode; // [R3]
         abortAllow <= abortReq & ~asleep & moduleEnable; // [R20]
         shiftAllow <= shiftReq & ~asleep & moduleEnable; // [R19]
         recovCountEn <= busOff & bitTick & ~asleep & moduleEnable &
                         ~powerDown; // [R18]
      end
   end

   // ============================================================
   // Time stamp capture at end of valid frame
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stampWrite <= 1'b0;
         stampValue <= 16'h0000;
         lastStamp_q <= 16'h0000;
      end else begin
         stampWrite <= frameEnd & timeEn & moduleEnable; // [R1]
         if (frameEnd && timeEn && moduleEnable) begin
            stampValue <= timerValue; // [R1]
            lastStamp_q <= timerValue;
         end
      end
   end

   // ============================================================
   // Wake-up flag and interrupt; set wins over clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wakeFlag_q <= 1'b0;
         wakeIrq <= 1'b0;
         pdn_q <= 1'b0;
      end else begin
         pdn_q <= powerDown;
         if (busActivity) begin
            wakeFlag_q <= 1'b1;
         end else if (wrTake && avsAddress == can_lpm_pkg::ADDR_STAT &&
                      avsByteEnable[0] &&
                      avsWriteData[can_lpm_pkg::STAT_WAKEF]) begin
            wakeFlag_q <= 1'b0;
         end
         wakeIrq <= busActivity & sleepReq & sleepAck_q & wakeEn &
                    wakeIrqEn; // [R8]
      end
   end

   // ============================================================
   // Avalon handshake: every request sees one wait state, so that
   // waitrequest itself comes straight from a flip-flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         avsWaitRequest <= 1'b1;
      end else begin
         // Low for the one cycle after a request is seen
         avsWaitRequest <= ~((avsRead | avsWrite) & avsWaitRequest);
      end
   end

   // Read data loaded at the first edge, stands in the answer cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         avsReadData <= can_lpm_pkg::ZERO32;
      end else begin
         if (rdLoad) begin
            case (avsAddress)
               can_lpm_pkg::ADDR_CTRL:
                  avsReadData <= {24'h00_0000, ctrl_q};
               can_lpm_pkg::ADDR_STAT:
                  avsReadData <= {28'h000_0000,
                                  mode_q == can_lpm_pkg::MODE_RECOVER,
                                  wakeFlag_q, pdn_q, sleepAck_q};
               can_lpm_pkg::ADDR_TIME:
                  avsReadData <= {16'h0000, lastStamp_q};
               default: avsReadData <= can_lpm_pkg::ZERO32;
            endcase
         end
      end
   end

   // ============================================================
   // Assertions
   // Pin stays recessive in listen-only and power-down
   tx_recessive_a: assert property ( // [R25]
      @(posedge mclk) disable iff (sys_rst)
      (listenOnly | powerDown) |=> busTransmitPin)
      else $error("transmit pin not recessive");
   no_listen_tx_a: assert property ( // [R3]
      @(posedge mclk) disable iff (sys_rst)
      listenOnly |=> !txStartAllow)
      else $error("transmit allowed in listen-only");
   pdn_clocks_a: assert property ( // [R7]
      @(posedge mclk) disable iff (sys_rst)
      powerDown |=> !regClkEn && !coreClkEn)
      else $error("clocks run in power-down");
   sleep_clocks_a: assert property ( // [R6]
      @(posedge mclk) disable iff (sys_rst)
      (asleep && moduleEnable && !powerDown) |=> regClkEn && !coreClkEn)
      else $error("sleep clock gating wrong");
   // Acknowledge only rises once transmit work is done
   ack_entry_a: assert property ( // [R13]
      @(posedge mclk) disable iff (sys_rst)
      $rose(sleepAck_q) |-> $past(!anyPending && !txActive))
      else $error("sleep entered with pending transmit");
   wake_irq_a: assert property ( // [R8]
      @(posedge mclk) disable iff (sys_rst)
      wakeIrq |-> $past(sleepAck_q && wakeEn && wakeIrqEn))
      else $error("wake interrupt without enables");
   no_abort_a: assert property ( // [R20]
      @(posedge mclk) disable iff (sys_rst)
      asleep |=> !abortAllow && !shiftAllow)
      else $error("abort or shift during sleep");
   stamp_capture_a: assert property ( // [R1]
      @(posedge mclk) disable iff (sys_rst)
      (frameEnd && timeEn && moduleEnable) |=>
      stampWrite && stampValue == $past(timerValue))
      else $error("time stamp not captured");
   rx_mask_a: assert property ( // [R21]
      @(posedge mclk) disable iff (sys_rst)
      (asleep && !wakeEn) |=> macRx)
      else $error("receive not masked in sleep");
   // Three cycles of sync delay before acknowledge may rise
   sync_delay_a: assert property ( // [R12]
      @(posedge mclk) disable iff (sys_rst)
      $rose(sleepReq) && mode_q == can_lpm_pkg::MODE_NORMAL
      && !powerDown && moduleEnable |=> !sleepAck_q [*3])
      else $error("sleep entered before sync delay");
endmodule : can_lowpower_mode_control
`default_nettype wire

// File: hw/can_lpm_pkg.sv
// Constants for the CAN low-power and mode control block.
// Assumes a single 40 MHz clock and an Avalon-MM register slave.
`default_nettype none
// ============================================================
// Package
package can_lpm_pkg;
   // Register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_TIME = 4'h8;
   // Control field positions
   localparam int CTRL_SLEEP = 0;
   localparam int CTRL_WAKE = 1;
   localparam int CTRL_WAKEIRQ = 2;
   localparam int CTRL_STOPWAI = 3;
   localparam int CTRL_LISTEN = 4;
   localparam int CTRL_TIMEEN = 5;
   localparam int CTRL_ENABLE = 6;
   localparam int CTRL_INIT = 7;
   // Status field positions
   localparam int STAT_ACK = 0;
   localparam int STAT_PDN = 1;
   localparam int STAT_WAKEF = 2;
   localparam int STAT_RECOV = 3;
   // Recessive bits needed after wake-up
   localparam logic [3:0] WAKE_IDLE_BITS = 4'hB;
   // Sleep request synchroniser delay in cycles
   localparam logic [1:0] SYNC_DELAY = 2'h2;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // Mode states
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_PENDING = 2'b01,
      MODE_SLEEP = 2'b10,
      MODE_RECOVER = 2'b11
   } mode_e;
endpackage : can_lpm_pkg
`default_nettype wire

// File: test/can_far_model.sv
// Far-side model: protocol engine bit timing and the bus receive line.
// Assumes mclk and sys_rst from the bench; burst asks for bus activity.
`default_nettype none
// ============================================================
// Bus model
module can_far_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic burst,
   output logic bitTick,
   output logic [15:0] timerValue,
   output logic busReceivePinRaw
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] divCnt_q; // Bit period divider
   // Eight clocks per bit, timer runs every clock
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         divCnt_q <= 3'h0;
         timerValue <= 16'h0000;
      end else begin
         divCnt_q <= divCnt_q + 3'h1;
         timerValue <= timerValue + 16'h0001;
      end
   end
   // One tick at the end of each bit
   assign bitTick = (divCnt_q == 3'h7);
   // Dominant for half of each bit while asked, recessive otherwise;
   // half-bit pulses outlast the three-stage synchroniser
   always_ff @(posedge mclk) begin
      busReceivePinRaw <= !(burst && divCnt_q[2]);
   end
endmodule : can_far_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the low-power and mode control block.
// Assumes the far-side model beside it and an Avalon-MM host here.
`default_nettype none
// ============================================================
// Bench top
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] SLP = ONE << can_lpm_pkg::CTRL_SLEEP;
   localparam logic [31:0] WK = ONE << can_lpm_pkg::CTRL_WAKE;
   localparam logic [31:0] WKI = ONE << can_lpm_pkg::CTRL_WAKEIRQ;
   localparam logic [31:0] SWI = ONE << can_lpm_pkg::CTRL_STOPWAI;
   localparam logic [31:0] LSN = ONE << can_lpm_pkg::CTRL_LISTEN;
   localparam logic [31:0] TEN = ONE << can_lpm_pkg::CTRL_TIMEEN;
   localparam logic [31:0] EN = ONE << can_lpm_pkg::CTRL_ENABLE;
   localparam logic [31:0] INI = ONE << can_lpm_pkg::CTRL_INIT;
   localparam logic [31:0] WKF = ONE << can_lpm_pkg::STAT_WAKEF;
   logic mclk = 1'h0, sysRst = 1'h1, burst = 1'h0; // Clock, reset
   logic [3:0] avsAddress = 4'h0; // Host bus request
   logic avsRead = 1'h0, avsWrite = 1'h0;
   logic [31:0] avsWriteData = 32'h0000_0000, rdq, avsReadData;
   logic cpuWait = 1'h0, cpuStop = 1'h0, frameEnd = 1'h0; // Engine side
   logic txActive = 1'h0, rxActive = 1'h0, busIdle = 1'h1;
   logic busOff = 1'h0, macTx = 1'h1, abortReq = 1'h0, shiftReq = 1'h0;
   logic [2:0] txBufferEmptyFlag = 3'h7;
   logic avsWaitRequest, busTransmitPin, macRx, coreClkEn, regClkEn;
   logic txStartAllow, abortAllow, shiftAllow, recovCountEn, stampWrite;
   logic wakeIrq, bitTick, busReceivePinRaw;
   logic [15:0] timerValue, stampValue, exp16;
   int fail_count = 0, compares = 0, irqCnt = 0, recCnt = 0, stCnt = 0;
   int n;
   always #12.5 mclk = !mclk; // 40 MHz
   can_lowpower_mode_control DUT (.mclk(mclk), .sys_rst(sysRst),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .cpuWait(cpuWait), .cpuStop(cpuStop), .bitTick(bitTick),
      .timerValue(timerValue), .frameEnd(frameEnd), .txActive(txActive),
      .rxActive(rxActive), .busIdle(busIdle), .busOff(busOff),
      .txBufferEmptyFlag(txBufferEmptyFlag), .macTx(macTx),
      .abortReq(abortReq), .shiftReq(shiftReq),
      .busReceivePinRaw(busReceivePinRaw), .busTransmitPin(busTransmitPin),
      .macRx(macRx), .coreClkEn(coreClkEn), .regClkEn(regClkEn),
      .txStartAllow(txStartAllow), .abortAllow(abortAllow),
      .shiftAllow(shiftAllow), .recovCountEn(recovCountEn),
      .stampWrite(stampWrite), .stampValue(stampValue), .wakeIrq(wakeIrq));
   can_far_model farEnd (.mclk(mclk), .sys_rst(sysRst), .burst(burst),
      .bitTick(bitTick), .timerValue(timerValue),
      .busReceivePinRaw(busReceivePinRaw));
   // Pulse counters for the one-cycle outputs
   always @(posedge mclk) begin
      irqCnt <= irqCnt + (wakeIrq === 1'h1);
      recCnt <= recCnt + (recovCountEn === 1'h1);
      stCnt <= stCnt + (stampWrite === 1'h1);
   end
   // ============================================================
   // Helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         fail_count++;
         $display("Error %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic idle(input int c);
      repeat (c) @(posedge mclk);
   endtask : idle
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= w;
      avsRead <= !w;
      // Only the watchdog ends a wait that never finishes
      do begin
         @(posedge mclk);
      end while (avsWaitRequest !== 1'h0);
      rdq = avsReadData;
      avsWrite <= 1'h0;
      avsRead <= 1'h0;
      @(posedge mclk);
   endtask : bus
   // Poll the acknowledge bit up to c reads
   task automatic ackIs(input logic v, input int c);
      for (int i = 0; i < c; i++) begin
         bus(1'h0, can_lpm_pkg::ADDR_STAT, 32'h0000_0000);
         if (rdq[can_lpm_pkg::STAT_ACK] === v) break;
      end
      chk(rdq[can_lpm_pkg::STAT_ACK], v);
   endtask : ackIs
   task print_verdict;
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // ============================================================
   // Scenarios
   task automatic tEnable;
      chk(coreClkEn, 1'h0);
      bus(1'h1, 4'hC, 32'hFFFF_FFFF);
      bus(1'h0, 4'hC, 32'h0000_0000);
      chk(rdq, 32'h0000_0000);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
      bus(1'h0, can_lpm_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(rdq[7:0], EN[7:0]);
      idle(150);
      chk(coreClkEn, 1'h1);
      chk(regClkEn, 1'h1);
   endtask : tEnable
   task automatic tStamp;
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | TEN);
      n = stCnt;
      frameEnd <= 1'h1;
      @(posedge mclk);
      exp16 = timerValue;
      frameEnd <= 1'h0;
      idle(3);
      chk(stCnt, n + 1);
      chk(stampValue, exp16);
      bus(1'h0, can_lpm_pkg::ADDR_TIME, 32'h0000_0000);
      chk(rdq[15:0], exp16);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
      frameEnd <= 1'h1;
      @(posedge mclk);
      frameEnd <= 1'h0;
      idle(3);
      chk(stCnt, n + 1);
   endtask : tStamp
   task automatic tListen;
      macTx <= 1'h0;
      txBufferEmptyFlag <= 3'h6;
      idle(6);
      chk(busTransmitPin, 1'h0);
      chk(txStartAllow, 1'h1);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | LSN);
      idle(6);
      chk(busTransmitPin, 1'h1);
      chk(macRx, 1'h0);
      chk(txStartAllow, 1'h0);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | INI);
      idle(4);
      chk(busTransmitPin, 1'h1);
      chk(txStartAllow, 1'h0);
      macTx <= 1'h1;
      txBufferEmptyFlag <= 3'h7;
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
   endtask : tListen
   task automatic tSleepIdle;
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SLP);
      ackIs(1'h1, 10);
      chk(coreClkEn, 1'h0);
      chk(regClkEn, 1'h1);
      abortReq <= 1'h1;
      shiftReq <= 1'h1;
      busOff <= 1'h1;
      macTx <= 1'h0;
      burst <= 1'h1;
      n = recCnt;
      idle(40);
      chk(macRx, 1'h1);
      chk(abortAllow, 1'h0);
      chk(shiftAllow, 1'h0);
      chk(recCnt, n);
      chk(busTransmitPin, 1'h1);
      burst <= 1'h0;
      ackIs(1'h1, 1);
      busOff <= 1'h0;
      macTx <= 1'h1;
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
      ackIs(1'h0, 10);
      idle(150);
      chk(abortAllow, 1'h1);
      chk(shiftAllow, 1'h1);
      busOff <= 1'h1;
      n = recCnt;
      idle(20);
      chk(recCnt != n, 1'h1);
      busOff <= 1'h0;
      abortReq <= 1'h0;
      shiftReq <= 1'h0;
   endtask : tSleepIdle
   task automatic tSleepTx;
      txBufferEmptyFlag <= 3'h5;
      txActive <= 1'h1;
      idle(4); // Schedule well before asking to sleep
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SLP);
      idle(20);
      ackIs(1'h0, 1);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
      txBufferEmptyFlag <= 3'h7;
      txActive <= 1'h0;
      ackIs(1'h1, 10);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN);
      ackIs(1'h0, 10);
      idle(150);
   endtask : tSleepTx
   task automatic tSleepRx;
      rxActive <= 1'h1;
      busIdle <= 1'h0;
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SLP);
      idle(20);
      ackIs(1'h0, 1);
      rxActive <= 1'h0;
      idle(10);
      ackIs(1'h0, 1);
      busIdle <= 1'h1;
      ackIs(1'h1, 10);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SLP | WK | WKI);
      n = irqCnt;
      burst <= 1'h1;
      idle(16);
      burst <= 1'h0;
      ackIs(1'h0, 10);
      chk(irqCnt, n + 1);
      bus(1'h0, can_lpm_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rdq[can_lpm_pkg::STAT_RECOV], 1'h1);
      chk(rdq[can_lpm_pkg::STAT_WAKEF], 1'h1);
      bus(1'h1, can_lpm_pkg::ADDR_STAT, WKF);
      idle(120);
      bus(1'h0, can_lpm_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rdq[can_lpm_pkg::STAT_RECOV], 1'h0);
      chk(rdq[can_lpm_pkg::STAT_WAKEF], 1'h0);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SLP | WK);
      ackIs(1'h1, 10);
      n = irqCnt;
      burst <= 1'h1;
      idle(16);
      burst <= 1'h0;
      ackIs(1'h0, 10);
      chk(irqCnt, n);
      idle(150);
   endtask : tSleepRx
   task automatic tPowerDown;
      macTx <= 1'h0;
      cpuStop <= 1'h1; // Level changed on the clock edge
      idle(4);
      chk(coreClkEn, 1'h0);
      chk(regClkEn, 1'h0);
      chk(busTransmitPin, 1'h1);
      cpuStop <= 1'h0;
      idle(150);
      cpuWait <= 1'h1;
      idle(4);
      chk(coreClkEn, 1'h1);
      chk(busTransmitPin, 1'h0);
      bus(1'h1, can_lpm_pkg::ADDR_CTRL, EN | SWI);
      idle(4);
      chk(coreClkEn, 1'h0);
      chk(busTransmitPin, 1'h1);
      cpuWait <= 1'h0;
      idle(150);
      chk(coreClkEn, 1'h1);
      chk(busTransmitPin, 1'h0);
      chk(txStartAllow, 1'h1);
   endtask : tPowerDown
   // ============================================================
   // Main sequence and watchdog
   initial begin
      repeat (6) @(posedge mclk);
      sysRst <= 1'h0;
      @(posedge mclk);
      tEnable;
      tStamp;
      tListen;
      tSleepIdle;
      tSleepTx;
      tSleepRx;
      tPowerDown;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
